//--- rtl/ufc_top.sv
// uart channel: special characters, auto rts/cts, flow-control characters, reset state
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "ufc_defs.svh"

// Summary of operation
// RULE1 - special detect compares second stop, sets status
// RULE2 - comparison bit 0 matches character lsb
// RULE3 - first pair mode: flow and special independent
// RULE4 - second pair: stop char dropped, two interrupts
// RULE5 - special detect off after reset
// RULE6 - auto rts: trigger interrupt, deassert upper level
// RULE7 - auto rts reasserts below next lower level
// RULE8 - software must assert rts bit first
// RULE9 - no auto rts: pin follows software bit
// RULE10 - auto cts halts transmit while input high
// RULE11 - auto cts and rts off after reset
// RULE12 - four read/write flow-control character registers
// RULE13 - divisor set only at power-up
// RULE14 - modem state: deltas zero, levels inverted
// RULE15 - reset drives pins to defined levels
// RULE16 - enhanced bits change only when unlocked
module ufc_top #(
  parameter int FILL_W = 5
) (
  // clock and resets
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              power_on_reset,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // receiver side
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic [FILL_W-1:0] rx_fill,
  output logic                   fifo_push,
  output logic      [7:0]        fifo_data,
  // transmitter side
  input  wire logic              tx_bit,
  input  wire logic              tx_space,
  output logic                   tx_allow,
  // modem inputs
  input  wire logic              cts_n,
  input  wire logic              dsr_n,
  input  wire logic              ri_n,
  input  wire logic              cd_n,
  // pins
  output logic                   tx_pin,
  output logic                   general_output_two_n,
  output logic                   rts_n,
  output logic                   dtr_n,
  output logic                   receive_ready_out_n,
  output logic                   transmit_ready_out_n,
  output logic                   irq,
  // divisor to the baud generator
  output logic      [7:0]        divisor_high,
  output logic      [7:0]        divisor_low,
  output logic      [7:0]        divisor_frac
);

  // ==========================================================
  // helpers
  // enhanced bits keep their old value unless writes are unlocked
  function automatic logic [7:0] enh_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask, input logic unlock);
    enh_merge = unlock ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction : enh_merge

  // trigger level for a selector; selectors past the top of the table give the full level
  function automatic logic [4:0] trig_level(input logic [2:0] sel);
    case (sel)
      3'h0:    trig_level = `UFC_TRIG_L0;
      3'h1:    trig_level = `UFC_TRIG_L1;
      3'h2:    trig_level = `UFC_TRIG_L2;
      3'h3:    trig_level = `UFC_TRIG_L3;
      default: trig_level = `UFC_FIFO_FULL;
    endcase
  endfunction : trig_level

  // ==========================================================
  // registers
  logic [7:0] efc_q;
  logic [7:0] resume1_q;
  logic [7:0] resume2_q;
  logic [7:0] stop1_q;
  logic [7:0] stop2_q;
  logic [7:0] mctl_q;
  logic [7:0] ien_q;
  logic [7:0] istat_q;
  logic [7:0] fctl_q;
  logic [7:0] divh_q;
  logic [7:0] divl_q;
  logic [7:0] divf_q;
  logic [3:0] mdelta_q;
  logic [3:0] mlevel_q;
  logic       soft_stop_q;
  logic       rts_hold_q;
  logic       trig_seen_q;
  logic [7:0] rdata_q;
  logic       push_q;
  logic [7:0] pdata_q;
  logic       tx_allow_q;
  logic       tx_pin_q;
  logic       op2_n_q;
  logic       rts_n_q;
  logic       dtr_n_q;
  logic       receive_ready_out_n_q;
  logic       transmit_ready_out_n_q;
  logic       irq_q;

  // write decode
  logic       wr_efc;
  logic       wr_mctl;
  logic       wr_ien;
  logic       wr_iclr;
  logic       wr_fctl;
  logic       unlock;
  logic       rd_mstate;

  assign unlock    = efc_q[`UFC_EFC_ENH];
  assign wr_efc    = reg_wr && (reg_addr == `UFC_A_EFC);
  assign wr_mctl   = reg_wr && (reg_addr == `UFC_A_MCTL);
  assign wr_ien    = reg_wr && (reg_addr == `UFC_A_IEN);
  assign wr_iclr   = reg_wr && (reg_addr == `UFC_A_ICLR);
  assign wr_fctl   = reg_wr && (reg_addr == `UFC_A_FCTL);
  assign rd_mstate = reg_rd && (reg_addr == `UFC_A_MSTATE);

  // ==========================================================
  // character matching
  ufc_match_if mif ();

  assign mif.rx_char = rx_data;
  assign mif.resume1 = resume1_q;
  assign mif.resume2 = resume2_q;
  assign mif.stop1   = stop1_q;
  assign mif.stop2   = stop2_q;

  ufc_char_match u_match (
    .m (mif.matcher)
  );

  // ==========================================================
  // receive decision
  ufc_pkg::ufc_rxf_mode_t rx_mode;
  logic              is_stop;
  logic              is_resume;
  logic              is_special;
  logic              set_spec;
  logic              store_char;

  assign rx_mode = ufc_pkg::ufc_rxf_mode_t'(efc_q[1:0]);

  // classify the incoming character by the compare mode
  always_comb begin
    is_stop   = 1'b0;
    is_resume = 1'b0;
    case (rx_mode)
      ufc_pkg::UFC_RXF_FIRST: begin
        is_stop   = mif.hit_stop1;  // [RULE3]
        is_resume = mif.hit_resume1;
      end
      ufc_pkg::UFC_RXF_SECOND: begin
        is_stop   = mif.hit_stop2;  // [RULE4]
        is_resume = mif.hit_resume2;
      end
      ufc_pkg::UFC_RXF_EITHER: begin
        is_stop   = mif.hit_stop1 || mif.hit_stop2;
        is_resume = mif.hit_resume1 || mif.hit_resume2;
      end
      default: begin
        is_stop   = 1'b0;
        is_resume = 1'b0;
      end
    endcase
  end

  // special detection runs only with its enable, which is clear after reset
  assign is_special = efc_q[`UFC_EFC_SPEC] && mif.hit_stop2;  // [RULE1] [RULE5]
  // a special stop char flags only with its interrupt enabled
  assign set_spec   = rx_valid && is_special &&
                      (!is_stop || ien_q[`UFC_IEN_SPEC]);  // [RULE4]
  // flow characters are consumed; a plain special char goes to the fifo
  assign store_char = rx_valid && !is_stop && !is_resume;  // [RULE1] [RULE4]

  // fifo write, one cycle after the character
  always_ff @(posedge clk) begin
    if (reset) begin
      push_q  <= 1'b0;
      pdata_q <= `UFC_RST_BYTE;
    end else begin
      push_q  <= store_char;
      pdata_q <= rx_data;
    end
  end

  // software stop state: stop char halts transmit, resume char releases it
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_stop_q <= 1'b0;
    end else if (rx_mode == ufc_pkg::UFC_RXF_OFF) begin
      soft_stop_q <= 1'b0;
    end else if (rx_valid && is_stop) begin
      soft_stop_q <= 1'b1;
    end else if (rx_valid && is_resume) begin
      soft_stop_q <= 1'b0;
    end
  end

  // ==========================================================
  // auto rts and trigger interrupt
  logic [2:0] tsel;
  logic [4:0] fill5;
  logic       at_trig;

  assign tsel    = {1'b0, fctl_q[7:6]};
  assign fill5   = 5'(rx_fill);
  assign at_trig = (fill5 >= trig_level(tsel));

  // hold off the remote between next upper and below next lower level
  always_ff @(posedge clk) begin
    if (reset) begin
      rts_hold_q <= 1'b0;
    end else if (!efc_q[`UFC_EFC_ARTS]) begin
      rts_hold_q <= 1'b0;
    end else if (fill5 >= trig_level(3'(tsel + 3'h1))) begin
      rts_hold_q <= 1'b1;  // [RULE6]
    end else if (fill5 < trig_level((tsel == 3'h0) ? tsel : 3'(tsel - 3'h1))) begin
      rts_hold_q <= 1'b0;  // [RULE7]
    end
  end

  // remember the trigger so one crossing gives one event
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_seen_q <= 1'b0;
    end else begin
      trig_seen_q <= at_trig;
    end
  end

  // ==========================================================
  // interrupt status, enable and clear
  logic [7:0] ev_set;
  logic [7:0] clr_mask;
  logic [7:0] ien_eff;

  // event set bits, one per status position
  always_comb begin
    ev_set                = 8'h00;
    ev_set[`UFC_ST_TRIG]   = at_trig && !trig_seen_q;  // [RULE6]
    ev_set[`UFC_ST_RESUME] = rx_valid && is_resume;
    ev_set[`UFC_ST_SPEC]   = set_spec;  // [RULE1]
    ev_set[`UFC_ST_STOP]   = rx_valid && is_stop;  // [RULE4]
  end

  // the enhanced status bits only clear while unlocked
  assign clr_mask = wr_iclr ? (unlock ? reg_wdata : (reg_wdata & ~`UFC_ENH_ISTAT))
                            : 8'h00;  // [RULE16]

  // status 4 and 5 take each other's enable bit
  always_comb begin
    ien_eff                = ien_q;
    ien_eff[`UFC_ST_SPEC]  = ien_q[`UFC_IEN_SPEC];
    ien_eff[`UFC_ST_STOP]  = ien_q[`UFC_IEN_STOP];
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      istat_q <= `UFC_RST_BYTE;
    end else begin
      istat_q <= (istat_q & ~clr_mask) | ev_set;
    end
  end

  // level interrupt while any enabled status bit is set
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;  // [RULE15]
    end else begin
      irq_q <= |(istat_q & ien_eff);
    end
  end

  // ==========================================================
  // control registers
  // auto cts and auto rts and special detect all start off
  always_ff @(posedge clk) begin
    if (reset) begin
      efc_q <= `UFC_RST_BYTE;  // [RULE5] [RULE11]
    end else if (wr_efc) begin
      efc_q <= reg_wdata;
    end
  end

  // flow-control character registers
  always_ff @(posedge clk) begin
    if (reset) begin
      resume1_q <= `UFC_RST_BYTE;
      resume2_q <= `UFC_RST_BYTE;
      stop1_q   <= `UFC_RST_BYTE;
      stop2_q   <= `UFC_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `UFC_A_RES1) begin
        resume1_q <= reg_wdata;  // [RULE12]
      end else if (reg_addr == `UFC_A_RES2) begin
        resume2_q <= reg_wdata;  // [RULE12]
      end else if (reg_addr == `UFC_A_STOP1) begin
        stop1_q <= reg_wdata;  // [RULE12]
      end else if (reg_addr == `UFC_A_STOP2) begin
        stop2_q <= reg_wdata;  // [RULE12]
      end
    end
  end

  // registers with locked enhanced bits
  always_ff @(posedge clk) begin
    if (reset) begin
      mctl_q <= `UFC_RST_BYTE;
      ien_q  <= `UFC_RST_BYTE;
      fctl_q <= `UFC_RST_BYTE;
      divf_q <= `UFC_RST_BYTE;
    end else begin
      if (wr_mctl) mctl_q <= enh_merge(mctl_q, reg_wdata, `UFC_ENH_MCTL, unlock);  // [RULE16]
      if (wr_ien)  ien_q  <= enh_merge(ien_q, reg_wdata, `UFC_ENH_IEN, unlock);    // [RULE16]
      if (wr_fctl) fctl_q <= enh_merge(fctl_q, reg_wdata, `UFC_ENH_FCTL, unlock);  // [RULE16]
      if (reg_wr && (reg_addr == `UFC_A_DIVF)) begin
        divf_q <= enh_merge(divf_q, reg_wdata, `UFC_ENH_DIVF, unlock);  // [RULE16]
      end
    end
  end

  // high and low divisor bytes answer only to the power-up reset, never the reset pin
  always_ff @(posedge clk) begin
    if (power_on_reset) begin
      divh_q <= `UFC_POR_DIVH;  // [RULE13]
      divl_q <= `UFC_POR_DIVL;  // [RULE13]
    end else if (reg_wr && (reg_addr == `UFC_A_DIVH)) begin
      divh_q <= reg_wdata;
    end else if (reg_wr && (reg_addr == `UFC_A_DIVL)) begin
      divl_q <= reg_wdata;
    end
  end

  // ==========================================================
  // modem state
  logic [3:0] mlevel_now;

  assign mlevel_now = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};

  // level sample runs free, valid even during reset
  always_ff @(posedge clk) begin
    mlevel_q <= mlevel_now;  // [RULE14]
  end

  // change flags: a read clears them, a change then still wins
  always_ff @(posedge clk) begin
    if (reset) begin
      mdelta_q <= 4'h0;  // [RULE14]
    end else begin
      mdelta_q <= (rd_mstate ? 4'h0 : mdelta_q) | (mlevel_now ^ mlevel_q);
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= `UFC_RST_BYTE;
    end else if (reg_rd) begin
      if (reg_addr == `UFC_A_EFC) begin
        rdata_q <= efc_q;
      end else if (reg_addr == `UFC_A_RES1) begin
        rdata_q <= resume1_q;
      end else if (reg_addr == `UFC_A_RES2) begin
        rdata_q <= resume2_q;
      end else if (reg_addr == `UFC_A_STOP1) begin
        rdata_q <= stop1_q;
      end else if (reg_addr == `UFC_A_STOP2) begin
        rdata_q <= stop2_q;
      end else if (reg_addr == `UFC_A_MCTL) begin
        rdata_q <= mctl_q;
      end else if (reg_addr == `UFC_A_MSTATE) begin
        rdata_q <= {mlevel_q, mdelta_q};  // [RULE14]
      end else if (reg_addr == `UFC_A_IEN) begin
        rdata_q <= ien_q;
      end else if (reg_addr == `UFC_A_ISTAT) begin
        rdata_q <= istat_q;
      end else if (reg_addr == `UFC_A_DIVL) begin
        rdata_q <= divl_q;
      end else if (reg_addr == `UFC_A_DIVH) begin
        rdata_q <= divh_q;
      end else if (reg_addr == `UFC_A_DIVF) begin
        rdata_q <= divf_q;
      end else if (reg_addr == `UFC_A_FCTL) begin
        rdata_q <= fctl_q;
      end else begin
        rdata_q <= 8'h00;  // clear register and holes
      end
    end
  end

  // ==========================================================
  // transmit gating and pins
  // auto cts only pauses; the transmitter finishes nothing mid-character here
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_allow_q <= 1'b1;
    end else begin
      tx_allow_q <= !(efc_q[`UFC_EFC_ACTS] && cts_n) && !soft_stop_q;  // [RULE10]
    end
  end

  // pins take their idle levels during reset
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_pin_q  <= 1'b1;  // [RULE15]
      op2_n_q   <= 1'b1;  // [RULE15]
      rts_n_q   <= 1'b1;  // [RULE15]
      dtr_n_q   <= 1'b1;  // [RULE15]
      receive_ready_out_n_q <= 1'b1;  // [RULE15]
      transmit_ready_out_n_q <= 1'b0;  // [RULE15]
    end else begin
      tx_pin_q  <= tx_bit;
      op2_n_q   <= !mctl_q[`UFC_MCTL_OUT2];
      // software bit must be asserted, auto hold can only deassert on top of it
      rts_n_q   <= !mctl_q[`UFC_MCTL_RTS] || rts_hold_q;  // [RULE8] [RULE9]
      dtr_n_q   <= !mctl_q[`UFC_MCTL_DTR];
      receive_ready_out_n_q <= (fill5 == 5'h00);
      transmit_ready_out_n_q <= !tx_space;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata            = rdata_q;
  assign fifo_push            = push_q;
  assign fifo_data            = pdata_q;
  assign tx_allow             = tx_allow_q;
  assign tx_pin               = tx_pin_q;
  assign general_output_two_n = op2_n_q;
  assign rts_n                = rts_n_q;
  assign dtr_n                = dtr_n_q;
  assign receive_ready_out_n  = receive_ready_out_n_q;
  assign transmit_ready_out_n = transmit_ready_out_n_q;
  assign irq                  = irq_q;
  assign divisor_high         = divh_q;
  assign divisor_low          = divl_q;
  assign divisor_frac         = divf_q;

endmodule : ufc_top

//--- rtl/ufc_defs.svh
// constants for the uart flow-control channel: register indices, fields, resets, levels
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// ==========================================================
// register indices on the plain register port
`define UFC_A_EFC       4'h0
`define UFC_A_RES1      4'h1
`define UFC_A_RES2      4'h2
`define UFC_A_STOP1     4'h3
`define UFC_A_STOP2     4'h4
`define UFC_A_MCTL      4'h5
`define UFC_A_MSTATE    4'h6
`define UFC_A_IEN       4'h7
`define UFC_A_ISTAT     4'h8
`define UFC_A_ICLR      4'h9
`define UFC_A_DIVL      4'hA
`define UFC_A_DIVH      4'hB
`define UFC_A_DIVF      4'hC
`define UFC_A_FCTL      4'hD

// ==========================================================
// field positions
`define UFC_EFC_ENH     4
`define UFC_EFC_SPEC    5
`define UFC_EFC_ARTS    6
`define UFC_EFC_ACTS    7
`define UFC_MCTL_DTR    0
`define UFC_MCTL_RTS    1
`define UFC_MCTL_OUT2   3
`define UFC_ST_TRIG     0
`define UFC_ST_RESUME   1
`define UFC_ST_SPEC     4
`define UFC_ST_STOP     5
`define UFC_IEN_SPEC    5
`define UFC_IEN_STOP    4

// ==========================================================
// masks of the bits that only change while enhanced writes are unlocked
`define UFC_ENH_IEN     8'hF0
`define UFC_ENH_ISTAT   8'h30
`define UFC_ENH_FCTL    8'h30
`define UFC_ENH_MCTL    8'hE0
`define UFC_ENH_DIVF    8'hFF

// ==========================================================
// reset values
`define UFC_RST_BYTE    8'h00
`define UFC_POR_DIVH    8'h00
`define UFC_POR_DIVL    8'h01

// ==========================================================
// receive fifo trigger levels
`define UFC_TRIG_L0     5'h01
`define UFC_TRIG_L1     5'h04
`define UFC_TRIG_L2     5'h08
`define UFC_TRIG_L3     5'h0E
`define UFC_FIFO_FULL   5'h10

`endif

//--- rtl/ufc_pkg.sv
// types shared by the uart flow-control channel
package ufc_pkg;

  // receive software flow-control compare mode, in field order 00,01,10,11
  typedef enum logic [1:0] {
    UFC_RXF_OFF,
    UFC_RXF_SECOND,
    UFC_RXF_FIRST,
    UFC_RXF_EITHER
  } ufc_rxf_mode_t;

  typedef logic [7:0] ufc_byte_t;

endpackage : ufc_pkg

//--- rtl/ufc_match_if.sv
// character compare bundle between the channel core and its matcher
`timescale 1ns/100ps
interface ufc_match_if;
  ufc_pkg::ufc_byte_t rx_char;
  ufc_pkg::ufc_byte_t resume1;
  ufc_pkg::ufc_byte_t resume2;
  ufc_pkg::ufc_byte_t stop1;
  ufc_pkg::ufc_byte_t stop2;
  logic               hit_resume1;
  logic               hit_resume2;
  logic               hit_stop1;
  logic               hit_stop2;

  modport core (output rx_char, resume1, resume2, stop1, stop2,
                input  hit_resume1, hit_resume2, hit_stop1, hit_stop2);
  modport matcher (input  rx_char, resume1, resume2, stop1, stop2,
                   output hit_resume1, hit_resume2, hit_stop1, hit_stop2);
endinterface : ufc_match_if

//--- rtl/ufc_char_match.sv
// compares a received character with the four flow-control characters
`timescale 1ns/100ps
module ufc_char_match (
  // compare bundle
  ufc_match_if.matcher m
);

  // ==========================================================
  // compare
  // whole-byte equality keeps bit 0 of each register against the character lsb
  function automatic logic same(input ufc_pkg::ufc_byte_t a, input ufc_pkg::ufc_byte_t b);
    same = (a == b);
  endfunction : same

  // purely combinational so the core decides in the cycle the character arrives
  assign m.hit_resume1 = same(m.rx_char, m.resume1);
  assign m.hit_resume2 = same(m.rx_char, m.resume2);
  assign m.hit_stop1   = same(m.rx_char, m.stop1);
  assign m.hit_stop2   = same(m.rx_char, m.stop2);  // [RULE2]

endmodule : ufc_char_match

//--- verif/ufc_far_fifo.sv
// receive fifo fill model standing behind the channel
`timescale 1ns/100ps
module ufc_far_fifo (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // fill traffic
  input  wire logic       push,
  input  wire logic       pop,
  output logic      [4:0] fill
);
  // one store per push, one drain per pop; saturates so a slip cannot wrap the count
  always_ff @(posedge clk) begin
    if (reset) begin
      fill <= 5'h00;
    end else if (push && !pop && fill != 5'h10) begin
      fill <= fill + 5'h01;
    end else if (pop && !push && fill != 5'h00) begin
      fill <= fill - 5'h01;
    end
  end
endmodule : ufc_far_fifo

//--- verif/ufc_top_assertions.sv
// port checker for the flow-control channel
`timescale 1ns/100ps
`include "ufc_defs.svh"
module ufc_top_chk (
  // clock and resets
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       power_on_reset,
  // register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // data paths
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       fifo_push,
  input wire logic [7:0] fifo_data,
  input wire logic       cts_n,
  input wire logic       tx_allow,
  // pins and divisor
  input wire logic       tx_pin,
  input wire logic       rts_n,
  input wire logic       irq,
  input wire logic [7:0] divisor_high,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_frac
);
  // ====================
  // shadow registers
  logic [7:0] efc_q;
  logic [7:0] mctl_q;
  logic [7:0] stop_q;
  default clocking dc @(posedge clk);
  endclocking
  // shadows track register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      efc_q  <= 8'h00;
      mctl_q <= 8'h00;
      stop_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `UFC_A_EFC) efc_q <= reg_wdata;
      if (reg_addr == `UFC_A_MCTL) mctl_q <= reg_wdata;
      if (reg_addr == `UFC_A_STOP2) stop_q <= reg_wdata;
    end
  end
  // ====================
  // assertions
  a_reset_pins: assert property (reset |=> tx_pin && rts_n && !irq && tx_allow)
    else $error("pins off reset level");
  a_por_div: assert property (
    power_on_reset |=> divisor_high == 8'h00 && divisor_low == 8'h01)
    else $error("divisor not preset");
  a_div_keep: assert property (
    reset && !power_on_reset && !reg_wr |=> $stable(divisor_high) && $stable(divisor_low))
    else $error("divisor moved in reset");
  a_push_data: assert property (disable iff (reset)
    fifo_push |-> $past(rx_valid) && fifo_data == $past(rx_data))
    else $error("pushed byte wrong");
  a_stop_drop: assert property (disable iff (reset)
    rx_valid && efc_q[1:0] == 2'b01 && rx_data == stop_q |=> !fifo_push)
    else $error("stop char pushed");
  a_cts_halt: assert property (disable iff (reset) efc_q[7] && cts_n |=> !tx_allow)
    else $error("sending while cts high");
  a_rts_gpo: assert property (disable iff (reset)
    !$past(efc_q[6]) && !$past(efc_q[6], 2) |-> rts_n == !$past(mctl_q[1]))
    else $error("rts not software level");
  a_frac_lock: assert property (disable iff (reset)
    !efc_q[4] && !$past(efc_q[4]) |=> $stable(divisor_frac))
    else $error("fraction moved while locked");
endmodule : ufc_top_chk

//--- verif/tb_top.sv
// self-checking bench for the flow-control channel
`timescale 1ns/100ps
`include "ufc_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  // ====================
  // design ports and bench state
  logic        clk, reset, power_on_reset, reg_wr, reg_rd, rx_valid, tx_bit, tx_space;
  logic        cts_n, dsr_n, ri_n, cd_n, pop, rd_d, fifo_push, tx_allow, tx_pin, irq;
  logic        general_output_two_n, rts_n, dtr_n, receive_ready_out_n, transmit_ready_out_n;
  logic [3:0]  reg_addr;
  logic [4:0]  rx_fill;
  logic [7:0]  reg_wdata, reg_rdata, rx_data, fifo_data, b, dh, dl, stop2;
  logic [7:0]  divisor_high, divisor_low, divisor_frac;
  logic [15:0] v;
  logic [15:0] rq[$];
  logic [7:0]  pq[$];
  int          errors, checks_done, i;
  wire  [6:0]  pins = {tx_pin, general_output_two_n, rts_n, dtr_n, receive_ready_out_n,
                       transmit_ready_out_n, irq};
  // design and far-side fifo model
  ufc_top ufc_top_i (.clk, .reset, .power_on_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_valid, .rx_data, .rx_fill, .fifo_push, .fifo_data, .tx_bit, .tx_space,
    .tx_allow, .cts_n, .dsr_n, .ri_n, .cd_n, .tx_pin, .general_output_two_n, .rts_n, .dtr_n,
    .receive_ready_out_n, .transmit_ready_out_n, .irq, .divisor_high, .divisor_low,
    .divisor_frac);
  ufc_far_fifo ufc_far_fifo_i (.clk, .reset, .push(fifo_push), .pop, .fill(rx_fill));
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict;
  end
  // ====================
  // tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back({m, e});
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd
  task automatic rx(input logic [7:0] d, input logic kept);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    if (kept) pq.push_back(d);
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : rx
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic rst2;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
  endtask : rst2
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // oldest notes against read data and pushes, mid-cycle
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      v = rq.pop_front();
      `CHK("reg_rdata", v[7:0], reg_rdata & v[15:8])
    end
    if (fifo_push) begin
      `CHK("fifo_push", 1'b1, pq.size() > 0)
      if (pq.size() > 0) `CHK("fifo_data", pq.pop_front(), fifo_data)
    end
  end
  // ====================
  // main sequence
  initial begin
    void'($urandom(32'h7ed5));
    {reg_wr, reg_rd, rx_valid, pop, reg_addr, reg_wdata, rx_data} = '0;
    {cd_n, ri_n, dsr_n, cts_n, tx_bit, tx_space} = 6'($urandom);
    reset = 1'b1;
    power_on_reset = 1'b1;
    b = 8'($urandom);
    stop2 = b + 8'h04;
    repeat (12) @(posedge clk);
    @(negedge clk);
    `CHK("divisor", 16'h0001, {divisor_high, divisor_low})
    `CHK("pins", 7'h7C, pins)
    @(posedge clk);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
    for (i = 0; i < 5; i++) rd(4'(i), 8'h00, 8'hFF);
    rd(`UFC_A_MSTATE, {~{cd_n, ri_n, dsr_n, cts_n}, 4'h0}, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    dh = 8'($urandom);
    dl = 8'($urandom);
    wr(`UFC_A_DIVH, dh);
    wr(`UFC_A_DIVL, dl);
    rst2;
    `CHK("divisor", {dh, dl}, {divisor_high, divisor_low})
    // locked enhanced bits, then unlocked
    wr(`UFC_A_IEN, 8'hF0);
    wr(`UFC_A_DIVF, 8'h5A);
    rd(`UFC_A_IEN, 8'h00, 8'hFF);
    settle(1);
    `CHK("divisor_frac", 8'h00, divisor_frac)
    wr(`UFC_A_EFC, 8'h10);
    wr(`UFC_A_IEN, 8'h20);
    rd(`UFC_A_IEN, 8'h20, 8'hFF);
    for (i = 1; i < 5; i++) wr(4'(i), b + 8'(i));
    for (i = 1; i < 5; i++) rd(4'(i), b + 8'(i), 8'hFF);
    // special off, then lsb near miss
    rx(stop2, 1'b1);
    rd(`UFC_A_ISTAT, 8'h00, 8'h32);
    wr(`UFC_A_EFC, 8'h30);
    rx(stop2 ^ 8'h01, 1'b1);
    rd(`UFC_A_ISTAT, 8'h00, 8'h32);
    // compare modes off, second pair, first pair
    for (i = 0; i < 3; i++) begin
      wr(`UFC_A_EFC, 8'h30 + 8'(i));
      rx(stop2, i != 1);
      rd(`UFC_A_ISTAT, (i == 1) ? 8'h30 : 8'h10, 8'h32);
      settle(0);
      `CHK("irq", 1'b1, irq)
      wr(`UFC_A_ICLR, 8'h30);
      wr(`UFC_A_EFC, 8'h30);
      settle(1);
      `CHK("irq", 1'b0, irq)
    end
    // hardware flow control after a mid-run reset
    rst2;
    @(posedge clk);
    cts_n <= 1'b1;
    settle(2);
    `CHK("tx_allow", 1'b1, tx_allow)
    wr(`UFC_A_MCTL, 8'h02);
    settle(1);
    `CHK("rts_n", 1'b0, rts_n)
    wr(`UFC_A_EFC, 8'h80);
    settle(2);
    `CHK("tx_allow", 1'b0, tx_allow)
    @(posedge clk);
    cts_n <= 1'b0;
    settle(2);
    `CHK("tx_allow", 1'b1, tx_allow)
    wr(`UFC_A_MCTL, 8'h00);
    settle(1);
    `CHK("rts_n", 1'b1, rts_n)
    wr(`UFC_A_MCTL, 8'h02);
    wr(`UFC_A_EFC, 8'h50);
    wr(`UFC_A_FCTL, 8'hC0);
    for (i = 0; i < 16; i++) rx(8'($urandom), 1'b1);
    settle(4);
    `CHK("rts_n", 1'b1, rts_n)
    rd(`UFC_A_ISTAT, 8'h01, 8'h01);
    pop <= 1'b1;
    repeat (8) @(posedge clk);
    pop <= 1'b0;
    settle(2);
    `CHK("rts_n", 1'b1, rts_n)
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    settle(2);
    `CHK("rts_n", 1'b0, rts_n)
    settle(2);
    `CHK("pending", 0, pq.size() + rq.size())
    give_verdict;
  end
endmodule : tb_top

bind ufc_top ufc_top_chk ufc_top_chk_i (.clk, .reset, .power_on_reset, .reg_addr, .reg_wdata,
  .reg_wr, .rx_valid, .rx_data, .fifo_push, .fifo_data, .cts_n, .tx_allow, .tx_pin, .rts_n,
  .irq, .divisor_high, .divisor_low, .divisor_frac);
